// File: design/sqm_pkg.sv
// Shared constants for the squib diagnostic and monitor SPI responder
package sqm_pkg;
  localparam int          FRAME_BITS    = 16;          // Bits in one SPI frame
  localparam logic [15:0] ERR_RESP      = 16'hd000;    // Error response word
  // Command and response bit positions
  localparam int          BIT_MODE_HI   = 15;          // Mode bit, always 1
  localparam int          BIT_MODE_LO   = 14;          // 0 diagnostic, 1 monitor
  localparam int          BIT_PARITY    = 13;          // Odd parity bit
  localparam int          BIT_WRITE     = 12;          // Execute (1) or read (0)
  localparam int          SEL_MSB       = 11;          // Selection field top
  localparam int          SEL_LSB       = 9;           // Selection field bottom
  localparam int          BIT_REPORT    = 8;           // Report source select
  localparam int          BIT_SQP       = 5;           // Squib pin choice
  localparam int          BIT_PDDIS     = 4;           // Pulldown disable
  localparam int          BIT_AMC       = 3;           // Amplifier calibrate
  localparam int          BIT_CHAN_BAD  = 2;           // Channel code above 3
  // Diagnostic selection codes
  localparam logic [2:0]  DIAG_STOP     = 3'h0;
  localparam logic [2:0]  DIAG_LEAK     = 3'h1;
  localparam logic [2:0]  DIAG_RESERVE  = 3'h2;
  localparam logic [2:0]  DIAG_SAFING   = 3'h3;
  localparam logic [2:0]  DIAG_RES      = 3'h4;
  localparam logic [2:0]  DIAG_HIGHRES  = 3'h5;
  localparam logic [2:0]  DIAG_LSSW     = 3'h6;
  localparam logic [2:0]  DIAG_HSSW     = 3'h7;
  // Register map, byte addresses
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_LASTCMD   = 8'h08;
  localparam int          CTRL_EN_BIT   = 0;           // SPI enable field
  localparam int          ST_ACTIVE_LSB = 4;           // Active flags in status
  localparam int          ST_REPORT_BIT = 8;           // Report select in status
  localparam logic        CTRL_EN_RST   = 1'b1;        // SPI enabled after reset
  localparam logic [3:0]  FLAGS_RST     = 4'h0;        // Deploy flags after reset
  localparam logic [4:0]  BITCNT_MAX    = 5'h11;       // Saturating bit count
  // Kind of the response to send next
  typedef enum logic [1:0] {
    RESP_DIAG,
    RESP_MON,
    RESP_ERR
  } sqm_resp_e;
endpackage

// File: design/sqm_spi_response.sv
// SPI command decoder and response builder for diagnostic and monitor mode 1
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module sqm_spi_response (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        spiCsN,
  input  wire logic        spiSclk,
  input  wire logic        spiMosi,
  output logic             spiMisoO,
  output logic             spiMisoOe,
  input  wire logic        batteryShortFlag,
  input  wire logic        groundShortFlag,
  input  wire logic        switchTestTimerActive,
  input  wire logic        priorFaultAbort,
  input  wire logic        safeAboveShort,
  input  wire logic        safeAboveOpen,
  input  wire logic        reserveAboveLo,
  input  wire logic        reserveAboveHi,
  input  wire logic        highResistanceFlag,
  input  wire logic [3:0]  activationExpired,
  input  wire logic [3:0]  armFireValid,
  input  wire logic [3:0]  deployTimeout,
  output logic      [2:0]  diagSelect,
  output logic      [1:0]  diagChannel,
  output logic             squibPinChoice,
  output logic             ampCalibrate,
  output logic             pulldownDisable,
  output logic      [3:0]  internalPulldown,
  output logic      [3:0]  deployInhibit
);

  // Parity bit that makes a 16-bit word odd, bit 13 treated as zero
  function automatic logic parityFor(input logic [15:0] w);
    logic [15:0] m;
    m = w;
    m[sqm_pkg::BIT_PARITY] = 1'b0;
    parityFor = ~(^m);
  endfunction

  // Odd parity check over a whole frame
  function automatic logic oddOk(input logic [15:0] w);
    oddOk = ^w;
  endfunction

  // Pin synchronisers: first stage is read only by the second
  logic [11:0] pinS1_q;            // First stage
  logic [11:0] pinS2_q;            // Second stage
  logic        csPrev_q;           // Delayed chip select for edges
  logic        sclkPrev_q;         // Delayed clock for edges
  wire  [11:0] pinRaw = {spiCsN, spiSclk, spiMosi, batteryShortFlag, groundShortFlag,
                         switchTestTimerActive, priorFaultAbort, safeAboveShort,
                         safeAboveOpen, reserveAboveLo, reserveAboveHi, highResistanceFlag};

  // Two flops per pin, chip select idles high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_q    <= 12'h800;
      pinS2_q    <= 12'h800;
      csPrev_q   <= 1'b1;
      sclkPrev_q <= 1'b0;
    end else begin
      pinS1_q    <= pinRaw;
      pinS2_q    <= pinS1_q;
      csPrev_q   <= pinS2_q[11];
      sclkPrev_q <= pinS2_q[10];
    end
  end

  // Named views of the synchronised pins
  wire csNS    = pinS2_q[11];
  wire sclkS   = pinS2_q[10];
  wire mosiS   = pinS2_q[9];
  wire batS    = pinS2_q[8];
  wire gndS    = pinS2_q[7];
  wire timerS  = pinS2_q[6];
  wire faultS  = pinS2_q[5];
  wire safShS  = pinS2_q[4];
  wire safOpS  = pinS2_q[3];
  wire resLoS  = pinS2_q[2];
  wire resHiS  = pinS2_q[1];
  wire hiResS  = pinS2_q[0];
  wire csFall  = csPrev_q & ~csNS;
  wire csRise  = ~csPrev_q & csNS;
  wire sclkUp  = ~sclkPrev_q & sclkS & ~csNS;
  wire sclkDn  = sclkPrev_q & ~sclkS & ~csNS;

  // Stored command state
  logic                 spiEn_q;       // Software enable for the SPI port
  logic [15:0]          rxShift_q;     // Incoming command bits
  logic [15:0]          txShift_q;     // Outgoing response bits
  logic [4:0]           bitCnt_q;      // Bits seen in this frame
  logic [15:0]          lastCmd_q;     // Last accepted command
  sqm_pkg::sqm_resp_e   kind_q;        // Kind of the next response
  logic [2:0]           sel_q;         // Diagnostic selection
  logic [1:0]           chan_q;        // Selected channel
  logic                 sqp_q;         // Squib pin choice
  logic                 pdDis_q;       // Pulldown disable
  logic                 amc_q;         // Calibrate request
  logic                 report_q;      // Report source select
  logic [3:0]           done_q;        // Deployment done flags
  logic [3:0]           active_q;      // Deployment active flags
  logic [3:0]           pulldown_q;    // Registered pulldown pattern
  logic                 miso_q;        // MISO data flop
  logic                 misoOe_q;      // MISO drive enable flop

  // Frame decode; a frame of the wrong length or parity is answered with error
  wire        frameOk  = spiEn_q && (bitCnt_q == 5'(sqm_pkg::FRAME_BITS)) && oddOk(rxShift_q);
  wire        accept   = csRise & frameOk;
  wire        isDiag   = rxShift_q[15:14] == 2'b10;
  wire        isMon1   = (rxShift_q[15:14] == 2'b11) && (rxShift_q[12:9] == 4'h0);
  wire        diagWr   = isDiag & rxShift_q[sqm_pkg::BIT_WRITE];
  wire        chanBad  = rxShift_q[sqm_pkg::BIT_CHAN_BAD];
  wire [2:0]  cmdSel   = rxShift_q[sqm_pkg::SEL_MSB:sqm_pkg::SEL_LSB];
  wire [3:0]  clearMask = (accept & isMon1) ? rxShift_q[3:0] : 4'h0;

  // Decision on what the frame does to the command state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kind_q    <= sqm_pkg::RESP_DIAG;
      sel_q     <= sqm_pkg::DIAG_STOP;
      chan_q    <= 2'h0;
      sqp_q     <= 1'b0;
      pdDis_q   <= 1'b0;
      amc_q     <= 1'b0;
      report_q  <= 1'b0;
      lastCmd_q <= 16'h0000;
    end else if (csRise && spiEn_q) begin
      if (!frameOk) begin
        // Broken frame only turns the next response into an error
        kind_q <= sqm_pkg::RESP_ERR;
      end else if (diagWr && chanBad) begin
        kind_q <= sqm_pkg::RESP_ERR;
      end else if (diagWr) begin
        kind_q    <= sqm_pkg::RESP_DIAG;
        sel_q     <= cmdSel;
        chan_q    <= rxShift_q[1:0];
        sqp_q     <= rxShift_q[sqm_pkg::BIT_SQP];
        pdDis_q   <= rxShift_q[sqm_pkg::BIT_PDDIS];
        // Calibrate only meaningful in the resistance diagnostic
        amc_q     <= rxShift_q[sqm_pkg::BIT_AMC] & (cmdSel == sqm_pkg::DIAG_RES);
        lastCmd_q <= rxShift_q;
      end else if (isDiag) begin
        // Read command: state kept, stored selection reported
        kind_q    <= sqm_pkg::RESP_DIAG;
        lastCmd_q <= rxShift_q;
      end else if (isMon1) begin
        kind_q    <= sqm_pkg::RESP_MON;
        report_q  <= rxShift_q[sqm_pkg::BIT_REPORT];
        lastCmd_q <= rxShift_q;
      end else begin
        // Other monitor modes are not handled here
        kind_q <= sqm_pkg::RESP_ERR;
      end
    end
  end

  // Deployment flags; a new event wins over a clear in the same cycle
  wire [3:0] doneNext   = (done_q & ~clearMask) | activationExpired;
  wire [3:0] activeNext = (active_q & ~deployTimeout) | armFireValid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_q   <= sqm_pkg::FLAGS_RST;
      active_q <= sqm_pkg::FLAGS_RST;
    end else begin
      done_q   <= doneNext;
      active_q <= activeNext;
    end
  end

  // Pulldown pattern: all on, all but the tested channel, or all off
  wire       testedMode = (sel_q == sqm_pkg::DIAG_LEAK) || (sel_q == sqm_pkg::DIAG_LSSW) ||
                          (sel_q == sqm_pkg::DIAG_HSSW);
  wire [3:0] chanOneHot = 4'h1 << chan_q;
  wire [3:0] pdNext     = pdDis_q ? 4'h0 : (testedMode ? ~chanOneHot : 4'hf);

  // Register the pattern so the pins come from flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulldown_q <= 4'hf;
    end else begin
      pulldown_q <= pdNext;
    end
  end

  // Result bits; the pulldown setting never enters them
  wire       swHold  = timerS | faultS;
  wire [1:0] swPair  = swHold ? 2'b00 : {batS & ~gndS, gndS & ~batS};
  wire [1:0] leakPair = {batS, gndS};
  wire [1:0] safPair = {safOpS, safShS | safOpS};
  wire [1:0] resPair = {resHiS, resLoS | resHiS};
  wire       swMode  = (sel_q == sqm_pkg::DIAG_LSSW) || (sel_q == sqm_pkg::DIAG_HSSW);
  wire [1:0] pairD8D7 = (sel_q == sqm_pkg::DIAG_LEAK)    ? leakPair :
                        swMode                           ? swPair   :
                        (sel_q == sqm_pkg::DIAG_SAFING)  ? safPair  :
                        (sel_q == sqm_pkg::DIAG_RESERVE) ? resPair  :
                        (sel_q == sqm_pkg::DIAG_HIGHRES) ? {hiResS, 1'b0} :
                        2'b00;
  wire       bitD6   = swMode & faultS;
  wire       bitD5   = swMode ? timerS : ((sel_q == sqm_pkg::DIAG_LEAK) & sqp_q);
  wire [2:0] chanFld = (sel_q == sqm_pkg::DIAG_STOP) ? 3'h0 : {1'b0, chan_q};

  // Response words before parity insertion
  wire [15:0] diagBody = {1'b1, 1'b0, 1'b0, 1'b1, sel_q, pairD8D7, bitD6, bitD5,
                          pdDis_q, amc_q, chanFld};
  wire [3:0]  monFlags = report_q ? active_q : done_q;
  wire [15:0] monBody  = {2'b11, 1'b0, 4'h0, report_q, 4'h0, monFlags};
  wire [15:0] body     = (kind_q == sqm_pkg::RESP_MON) ? monBody : diagBody;
  wire [15:0] respWord = (kind_q == sqm_pkg::RESP_ERR) ? sqm_pkg::ERR_RESP :
                         {body[15:14], parityFor(body), body[12:0]};

  // SPI shifting: response loaded at select, so flags are caught at that edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxShift_q <= 16'h0000;
      txShift_q <= 16'h0000;
      bitCnt_q  <= 5'h00;
      miso_q    <= 1'b0;
      misoOe_q  <= 1'b0;
    end else begin
      misoOe_q <= ~csNS & spiEn_q;
      if (csFall) begin
        txShift_q <= respWord;
        miso_q    <= respWord[15];
        bitCnt_q  <= 5'h00;
      end else if (sclkUp) begin
        // Sample on rising edge, count saturates past a full frame
        rxShift_q <= {rxShift_q[14:0], mosiS};
        if (bitCnt_q != sqm_pkg::BITCNT_MAX) begin
          bitCnt_q <= bitCnt_q + 5'h01;
        end
      end else if (sclkDn) begin
        txShift_q <= {txShift_q[14:0], 1'b0};
        miso_q    <= txShift_q[14];
      end
    end
  end

  // Wishbone slave: one wait state, ack drops after one cycle
  logic        ack_q;
  logic [31:0] rdat_q;
  wire         wbReq   = wb_cyc_i & wb_stb_i & ~ack_q;
  // Write lands at the edge where the master sees ack, while it still holds the request
  wire         ctrlWr  = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0] &
                         (wb_adr_i == sqm_pkg::REG_CTRL);
  wire [31:0]  statusW = {23'h0, report_q, active_q, done_q};
  wire [31:0]  readMux = (wb_adr_i == sqm_pkg::REG_CTRL)    ? {31'h0, spiEn_q} :
                         (wb_adr_i == sqm_pkg::REG_STATUS)  ? statusW :
                         (wb_adr_i == sqm_pkg::REG_LASTCMD) ? {16'h0, lastCmd_q} :
                         32'h0;

  // Bus registers; unmapped addresses read zero and still ack
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0;
      spiEn_q <= sqm_pkg::CTRL_EN_RST;
    end else begin
      ack_q <= wbReq;
      if (wbReq) begin
        rdat_q <= readMux;
      end
      if (ctrlWr) begin
        spiEn_q <= wb_dat_i[sqm_pkg::CTRL_EN_BIT];
      end
    end
  end

  // Outputs, all from flops
  assign wb_dat_o         = rdat_q;
  assign wb_ack_o         = ack_q;
  assign spiMisoO         = miso_q;
  assign spiMisoOe        = misoOe_q;
  assign diagSelect       = sel_q;
  assign diagChannel      = chan_q;
  assign squibPinChoice   = sqp_q;
  assign ampCalibrate     = amc_q;
  assign pulldownDisable  = pdDis_q;
  assign internalPulldown = pulldown_q;
  assign deployInhibit    = done_q;

  // Checks on the response builder and flags
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_leak;
    (kind_q == sqm_pkg::RESP_DIAG && sel_q == sqm_pkg::DIAG_LEAK) |->
      respWord[8:7] == {batS, gndS};
  endproperty
  a_leak: assert property (p_leak) else $error("leak pair wrong");

  property p_swHold;
    (kind_q == sqm_pkg::RESP_DIAG && swMode && swHold) |-> respWord[8:6] == {2'b00, faultS};
  endproperty
  a_swHold: assert property (p_swHold) else $error("switch hold pair wrong");
  property p_hsPass;
    (kind_q == sqm_pkg::RESP_DIAG && sel_q == sqm_pkg::DIAG_HSSW && !swHold && batS && !gndS)
      |-> respWord[8:7] == 2'b10;
  endproperty
  a_hsPass: assert property (p_hsPass) else $error("high side pass wrong");
  property p_safMid;
    (kind_q == sqm_pkg::RESP_DIAG && sel_q == sqm_pkg::DIAG_SAFING && safShS && !safOpS)
      |-> respWord[8:7] == 2'b01;
  endproperty
  a_safMid: assert property (p_safMid) else $error("safing mid wrong");
  property p_chanErr;
    (accept && diagWr && chanBad) |=> respWord == sqm_pkg::ERR_RESP;
  endproperty
  a_chanErr: assert property (p_chanErr) else $error("bad channel not error");
  property p_parity;
    csFall |=> oddOk(txShift_q) && (miso_q == txShift_q[15]);
  endproperty
  a_parity: assert property (p_parity) else $error("response parity even");
  property p_doneSet;
    activationExpired[0] |=> done_q[0] [*2] or (done_q[0] ##1 $fell(done_q[0]));
  endproperty
  a_doneSet: assert property (p_doneSet) else $error("done flag not set");
  property p_doneClr;
    (clearMask[0] && !activationExpired[0]) |=> !done_q[0] && !deployInhibit[0];
  endproperty
  a_doneClr: assert property (p_doneClr) else $error("done flag not cleared");
  property p_pdOff;
    pdDis_q [*2] |-> internalPulldown == 4'h0;
  endproperty
  a_pdOff: assert property (p_pdOff) else $error("pulldowns not off");
  property p_monResp;
    kind_q == sqm_pkg::RESP_MON |-> respWord[7:4] == 4'h0 && respWord[8] == report_q;
  endproperty
  a_monResp: assert property (p_monResp) else $error("monitor response wrong");

  c_diag: cover property (accept && diagWr && !chanBad);
  c_mon:  cover property (accept && isMon1 && rxShift_q[3:0] != 4'h0);
  c_err:  cover property (csRise && spiEn_q && !frameOk);

endmodule

`default_nettype wire

// File: verif/sqm_spi_host.sv
// SPI host model that sends command frames and collects responses
`timescale 1ns/10ps
`default_nettype none
module sqm_spi_host (
  input  wire logic clock,
  input  wire logic miso,
  input  wire logic misoOe,
  output var logic  csN,
  output var logic  sclk,
  output var logic  mosi
);
  logic lastBit; // Last level seen on the response line
  // Deselected and idle until the first frame
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    lastBit = 1'b0;
  end
  // Half a 64 ns link period, counted on the system clock
  task automatic tick();
    repeat (4) @(posedge clock);
  endtask
  // One frame, MSB first; bad corrupts the parity on purpose
  task automatic xfer(input logic [15:0] cmd, input logic bad, output logic [15:0] rsp);
    logic [15:0] f;
    f = cmd;
    f[13] = ~^{cmd[15:14], cmd[12:0]} ^ bad;
    @(posedge clock);
    csN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi <= f[i];
      tick();
      // An undriven line drifts rather than holding its last level
      lastBit = misoOe ? miso : ~lastBit;
      rsp[i] = lastBit;
      sclk <= 1'b1;
      tick();
      sclk <= 1'b0;
    end
    tick();
    csN <= 1'b1;
    mosi <= ~mosi;
    // Clock stands still between frames
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// File: verif/sqm_spi_response_test.sv
// Self-checking bench for the squib diagnostic SPI responder
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module sqm_spi_response_test;
  logic        clock = 1'b0;                               // System clock
  logic        rst_n = 1'b0;                               // Reset, held at start
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, spiCsN, spiSclk, spiMosi, spiMisoO, spiMisoOe;
  logic        bat = 1'b0, gnd = 1'b0, tmr = 1'b0, pf = 1'b0;  // Comparator levels
  logic        sLo = 1'b0, sHi = 1'b0, rLo = 1'b0, rHi = 1'b0, hr = 1'b0;
  logic [3:0]  expd = 4'h0, arm = 4'h0, tmo = 4'h0;           // Deploy event pulses
  logic [2:0]  diagSelect;
  logic [1:0]  diagChannel;
  logic        squibPinChoice, ampCalibrate, pulldownDisable, pd;
  logic [3:0]  internalPulldown, deployInhibit, pde;
  int          miscompares = 0, tests_run = 0;
  // Reference state: last accepted command, error and flags
  logic [15:0] lastCmd = 16'h9000, g, w;
  logic        lastErr = 1'b0, rs = 1'b0, mon = 1'b0;  // Error, report source, monitor answer
  logic [3:0]  done = 4'h0, act = 4'h0;

  always #4 clock = ~clock;

  sqm_spi_response sqm_spi_response_i (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiMosi(spiMosi), .spiMisoO(spiMisoO), .spiMisoOe(spiMisoOe),
    .batteryShortFlag(bat), .groundShortFlag(gnd), .switchTestTimerActive(tmr),
    .priorFaultAbort(pf), .safeAboveShort(sLo), .safeAboveOpen(sHi),
    .reserveAboveLo(rLo), .reserveAboveHi(rHi), .highResistanceFlag(hr),
    .activationExpired(expd), .armFireValid(arm), .deployTimeout(tmo),
    .diagSelect(diagSelect), .diagChannel(diagChannel), .squibPinChoice(squibPinChoice),
    .ampCalibrate(ampCalibrate), .pulldownDisable(pulldownDisable),
    .internalPulldown(internalPulldown), .deployInhibit(deployInhibit));

  sqm_spi_host sqm_spi_host_i (
    .clock(clock), .miso(spiMisoO), .misoOe(spiMisoOe), .csN(spiCsN), .sclk(spiSclk),
    .mosi(spiMosi));

  function automatic logic [15:0] par(input logic [15:0] v);
    par = v;
    par[13] = ~^{v[15:14], v[12:0]};
  endfunction

  // Response the responder owes for the last accepted command
  function automatic logic [15:0] want_resp();
    logic [15:0] r;
    logic [2:0]  s;
    s = lastCmd[11:9];
    r = {4'h9, s, 4'h0, lastCmd[4], 4'h0};
    r[3] = (s == 3'h4) & lastCmd[3];
    if (s != 3'h0) r[1:0] = lastCmd[1:0];
    case (s)
      3'h1: r[8:5] = {bat, gnd, 1'b0, lastCmd[5]};
      3'h2: r[8:7] = {rHi, rLo | rHi};
      3'h3: r[8:7] = {sHi, sLo | sHi};
      3'h5: r[8] = hr;
      3'h6, 3'h7: r[8:5] = {(tmr | pf) ? 2'b00 : {bat & ~gnd, gnd & ~bat}, pf, tmr};
      default: ;
    endcase
    if (mon) r = {4'hc, 3'h0, rs, 4'h0, rs ? act : done};
    want_resp = lastErr ? 16'hd000 : par(r);
  endfunction

  // One frame; the answer seen belongs to the frame before
  task automatic send(input logic [15:0] cmd, input logic bad);
    w = want_resp();
    sqm_spi_host_i.xfer(cmd, bad, g);
    // Errors: bad parity, other monitor modes, bad channel on a diagnostic write
    lastErr = bad | (cmd[14] ? (cmd[12:9] != 4'h0) : (cmd[12] & cmd[2]));
    if (!lastErr) begin
      mon = cmd[14];
      if (cmd[14]) begin
        rs = cmd[8];
        done = done & ~cmd[3:0];
      end else if (cmd[12]) begin
        lastCmd = par(cmd);
      end
    end
  endtask

  // Classic single-cycle bus access, held until acknowledged
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
    @(posedge clock);
    // No wait length is assumed; only the watchdog ends a hung access
    while (wb_ack_o !== 1'b1) begin
      @(posedge clock);
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK({internalPulldown, deployInhibit}, 8'hf0)
    wb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h1)
    wb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h0)
    // Every diagnostic but stop against 16 comparator patterns
    for (int s = 1; s < 8; s++) begin
      for (int k = 0; k < 16; k++) begin
        @(posedge clock);
        {pf, tmr, gnd, bat} <= k[3:0];
        {sHi, sLo, rHi, rLo, hr} <= {k[0] & k[1], k[0], k[2] & k[3], k[2], k[1]};
        pd = k[1] ^ k[2];
        pde = pd ? 4'h0 : (s == 1 || s > 5) ? ~(4'h1 << k[1:0]) : 4'hf;
        repeat (4) @(posedge clock);
        send({4'h9, s[2:0], 3'h0, k[3], pd, 2'b10, k[1:0]}, 1'b0);
        `CHK(g, w)
        `CHK({diagSelect, diagChannel, squibPinChoice}, {s[2:0], k[1:0], k[3]})
        `CHK({ampCalibrate, pulldownDisable}, {s == 4, pd})
        `CHK(internalPulldown, pde)
      end
    end
    // Bad channel codes, then a corrupt parity frame, leave state alone
    for (int c = 4; c < 9; c++) begin
      send({4'h9, 3'h1, 6'h0, c[2:0]}, c == 8);
      `CHK(g, w)
      `CHK(diagSelect, 3'h7)
    end
    wb(1'b0, 8'h08, 32'h0);
    `CHK(rd, {16'h0, lastCmd})
    // A read keeps the stored diagnostic; monitor mode 2 is answered with error
    send(16'h81e1, 1'b0);
    `CHK(g, w)
    send(16'hc400, 1'b0);
    `CHK(g, w)
    // Frames are ignored while the port is switched off
    wb(1'b1, 8'h00, 32'h0);
    sqm_spi_host_i.xfer(16'h9200, 1'b0, g);
    `CHK({spiMisoOe, diagSelect}, 4'h7)
    wb(1'b1, 8'h00, 32'h1);
    // Deploy flags: set, report both sources, clear
    @(posedge clock);
    {expd, arm} <= 8'hb1;
    @(posedge clock);
    {expd, arm} <= 8'h00;
    {done, act} = 8'hb1;
    repeat (4) @(posedge clock);
    `CHK(deployInhibit, 4'hb)
    wb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h1b)
    send(16'hc008, 1'b0);
    `CHK(g, w)
    send(16'hc100, 1'b0);
    `CHK(g, w)
    `CHK(deployInhibit, 4'h3)
    send(16'hc100, 1'b0);
    `CHK(g, w)
    @(posedge clock);
    tmo <= 4'h1;
    @(posedge clock);
    tmo <= 4'h0;
    act = 4'h0;
    repeat (4) @(posedge clock);
    send(16'hc00f, 1'b0);
    `CHK(g, w)
    send(16'h9000, 1'b0);
    `CHK(g, w)
    `CHK(deployInhibit, 4'h0)
    end_of_test();
  end
endmodule
`default_nettype wire
